// ==== hdl/zero_cross_detector.sv ====
// zero-cross detector digital logic with an AHB-Lite register slave
`default_nettype none
module zero_cross_detector
	import zero_cross_pkg::*;
(
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic sink_active_in,
	input wire logic always_active_cfg_n,
	input wire logic pps_data_in,
	input wire logic tris_in,
	output logic regulator_en,
	output logic pad_out,
	output logic pad_oe,
	output logic irq
);

	// ***************************************************************
	// declarations
	// ***************************************************************
	logic en_r, en_nxt;
	logic pol_r, pol_nxt;
	logic rise_en_r, rise_en_nxt;
	logic fall_en_r, fall_en_nxt;
	logic flag_r, flag_nxt;
	logic mask_r, mask_nxt;
	logic gie_r, gie_nxt;
	logic peripheral_irq_enable_r, peripheral_irq_enable_nxt;
	logic cfg_n_r, cfg_n_nxt;
	logic cfg_taken_r, cfg_taken_nxt;
	logic dp_wr_r, dp_wr_nxt;
	logic [7:0] dp_addr_r, dp_addr_nxt;
	logic [31:0] hrdata_nxt;
	logic regulator_en_nxt, pad_out_nxt, pad_oe_nxt, irq_nxt;
	logic addr_ok;
	logic wr_ctrl, wr_flag, wr_mask, wr_ictl;
	logic flag_set, flag_clr, active;
	logic out_level, rise, fall;

	// ***************************************************************
	// helpers
	// ***************************************************************
	// places one bit into a word, all other bits read as zero
	function automatic logic [31:0] bit_word(input logic val, input int pos);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[pos] = val;
		return w;
	endfunction

	// ***************************************************************
	// sink flag synchroniser and edge detection
	// ***************************************************************
	// the analog loop picks sink above the reference and source below it;
	// this logic only observes which one is active
	zc_edge_detect u_edge (
		.core_clk(core_clk),
		.rstn(rstn),
		.sink_async(sink_active_in),
		.invert(pol_r),
		.out_level(out_level),
		.rise(rise),
		.fall(fall)
	);

	// ***************************************************************
	// bus address and data phase
	// ***************************************************************
	// only whole-word writes are taken; other sizes are ignored, answer stays OKAY
	assign addr_ok = hsel & hready & htrans[HTRANS_VALID_BIT];

	always_comb begin
		dp_wr_nxt = addr_ok & hwrite & (hsize == HSIZE_WORD);
		dp_addr_nxt = addr_ok ? (haddr[7:0] & OFS_MASK) : dp_addr_r;
	end

	// data phase write strobes; unmapped offsets decode to nothing
	always_comb begin
		wr_ctrl = 1'b0;
		wr_flag = 1'b0;
		wr_mask = 1'b0;
		wr_ictl = 1'b0;
		if (dp_wr_r && dp_addr_r == CTRL_OFS) begin
			wr_ctrl = 1'b1;
		end else if (dp_wr_r && dp_addr_r == FLAG_OFS) begin
			wr_flag = 1'b1;
		end else if (dp_wr_r && dp_addr_r == MASK_OFS) begin
			wr_mask = 1'b1;
		end else if (dp_wr_r && dp_addr_r == ICTL_OFS) begin
			wr_ictl = 1'b1;
		end
	end

	// ***************************************************************
	// control and interrupt registers
	// ***************************************************************
	// the status bit at position 5 is read-only, writes to it are dropped
	always_comb begin
		en_nxt = wr_ctrl ? hwdata[CTRL_EN_BIT] : en_r;
		pol_nxt = wr_ctrl ? hwdata[CTRL_POL_BIT] : pol_r;
		rise_en_nxt = wr_ctrl ? hwdata[CTRL_RISE_BIT] : rise_en_r;
		fall_en_nxt = wr_ctrl ? hwdata[CTRL_FALL_BIT] : fall_en_r;
		mask_nxt = wr_mask ? hwdata[MASK_BIT] : mask_r;
		gie_nxt = wr_ictl ? hwdata[ICTL_GIE_BIT] : gie_r;
		peripheral_irq_enable_nxt = wr_ictl ? hwdata[ICTL_PERIPHERAL_IRQ_ENABLE_BIT] : peripheral_irq_enable_r;
	end

	// each detector only counts when its own enable is set; the detector
	// enable does not gate it, so a polarity write alone can raise the flag
	assign flag_set = (rise & rise_en_r) | (fall & fall_en_r);
	assign flag_clr = wr_flag & hwdata[FLAG_BIT];

	// sticky flag: a set in the clearing cycle survives the clear
	always_comb begin
		flag_nxt = flag_set | (flag_r & ~flag_clr);
	end

	// request leaves only with flag and every enable along the path
	always_comb begin
		irq_nxt = flag_nxt & mask_nxt & peripheral_irq_enable_nxt & gie_nxt;
	end

	// ***************************************************************
	// configuration strap and pin control
	// ***************************************************************
	// the nonvolatile bit is static; caught once at the first edge after reset
	always_comb begin
		cfg_taken_nxt = 1'b1;
		cfg_n_nxt = cfg_taken_r ? cfg_n_r : always_active_cfg_n;
	end

	// with the strap cleared the enable bit has no say at all
	assign active = ~cfg_n_nxt | en_nxt;

	// no sleep input gates anything here: the block lives on core_clk alone,
	// which the system keeps running for this block while asleep
	always_comb begin
		regulator_en_nxt = active;
		pad_oe_nxt = active ? 1'b0 : ~tris_in;
		pad_out_nxt = active ? 1'b0 : pps_data_in;
	end

	// ***************************************************************
	// read data
	// ***************************************************************
	// built from next values so a read right after a write sees the new data
	always_comb begin
		hrdata_nxt = 32'h0000_0000;
		if (addr_ok && !hwrite) begin
			if (haddr[7:0] == CTRL_OFS) begin
				hrdata_nxt = bit_word(en_nxt, CTRL_EN_BIT)
					| bit_word(out_level, CTRL_OUT_BIT)
					| bit_word(pol_nxt, CTRL_POL_BIT)
					| bit_word(rise_en_nxt, CTRL_RISE_BIT)
					| bit_word(fall_en_nxt, CTRL_FALL_BIT);
			end else if (haddr[7:0] == FLAG_OFS) begin
				hrdata_nxt = bit_word(flag_nxt, FLAG_BIT);
			end else if (haddr[7:0] == MASK_OFS) begin
				hrdata_nxt = bit_word(mask_nxt, MASK_BIT);
			end else if (haddr[7:0] == ICTL_OFS) begin
				hrdata_nxt = bit_word(gie_nxt, ICTL_GIE_BIT) | bit_word(peripheral_irq_enable_nxt, ICTL_PERIPHERAL_IRQ_ENABLE_BIT);
			end
		end
	end

	// ***************************************************************
	// state registers
	// ***************************************************************
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			en_r <= CTRL_EN_RST;
			pol_r <= CTRL_POL_RST;
			rise_en_r <= CTRL_RISE_RST;
			fall_en_r <= CTRL_FALL_RST;
			flag_r <= FLAG_RST;
			mask_r <= MASK_RST;
			gie_r <= GIE_RST;
			peripheral_irq_enable_r <= PERIPHERAL_IRQ_ENABLE_RST;
			cfg_n_r <= CFG_N_RST;
			cfg_taken_r <= 1'b0;
			dp_wr_r <= 1'b0;
			dp_addr_r <= 8'h00;
		end else begin
			en_r <= en_nxt;
			pol_r <= pol_nxt;
			rise_en_r <= rise_en_nxt;
			fall_en_r <= fall_en_nxt;
			flag_r <= flag_nxt;
			mask_r <= mask_nxt;
			gie_r <= gie_nxt;
			peripheral_irq_enable_r <= peripheral_irq_enable_nxt;
			cfg_n_r <= cfg_n_nxt;
			cfg_taken_r <= cfg_taken_nxt;
			dp_wr_r <= dp_wr_nxt;
			dp_addr_r <= dp_addr_nxt;
		end
	end

	// output flops; the slave never inserts wait states
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= HRESP_OKAY;
			regulator_en <= 1'b1;
			pad_out <= 1'b0;
			pad_oe <= 1'b0;
			irq <= 1'b0;
		end else begin
			hrdata <= hrdata_nxt;
			hreadyout <= 1'b1;
			hresp <= HRESP_OKAY;
			regulator_en <= regulator_en_nxt;
			pad_out <= pad_out_nxt;
			pad_oe <= pad_oe_nxt;
			irq <= irq_nxt;
		end
	end

	// ***************************************************************
	// assertions
	// ***************************************************************
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rstn);

	sequence s_enabled_edge;
		(rise && rise_en_r) || (fall && fall_en_r);
	endsequence

	property p_flag_set;
		s_enabled_edge |=> flag_r;
	endproperty
	a_flag_set: assert property (p_flag_set)
		else $error("enabled edge did not set the flag");

	property p_flag_quiet;
		(!flag_r && !(rise && rise_en_r) && !(fall && fall_en_r)) |=> !flag_r;
	endproperty
	a_flag_quiet: assert property (p_flag_quiet)
		else $error("flag set without an enabled edge");

	property p_flag_hold;
		(flag_r && !(wr_flag && hwdata[FLAG_BIT])) |=> flag_r;
	endproperty
	a_flag_hold: assert property (p_flag_hold)
		else $error("flag dropped without a software clear");

	property p_irq;
		##1 (irq == (flag_r && mask_r && peripheral_irq_enable_r && gie_r));
	endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt output disagrees with flag and enables");

	property p_pad;
		(cfg_taken_r && en_r) |-> (regulator_en && !pad_oe);
	endproperty
	a_pad: assert property (p_pad)
		else $error("enabled detector pin not in regulating drive");

	property p_always_on;
		(cfg_taken_r && !cfg_n_r) |-> regulator_en;
	endproperty
	a_always_on: assert property (p_always_on)
		else $error("cleared strap did not keep the detector active");

	property p_status_read;
		(addr_ok && !hwrite && haddr[7:0] == CTRL_OFS)
			|=> (hrdata[CTRL_OUT_BIT] == $past(out_level));
	endproperty
	a_status_read: assert property (p_status_read)
		else $error("control read does not show the logic output");

endmodule // zero_cross_detector
`default_nettype wire

// ==== hdl/zero_cross_pkg.sv ====
// package: register map, field positions, reset values and bus codes of the zero-cross detector
`default_nettype none
package zero_cross_pkg;

	// ***************************************************************
	// register offsets (byte addresses, one word each)
	// ***************************************************************
	localparam logic [7:0] CTRL_OFS = 8'h00; // zero_cross_control
	localparam logic [7:0] FLAG_OFS = 8'h04; // sticky event status, write one to clear
	localparam logic [7:0] MASK_OFS = 8'h08; // per-event interrupt enable
	localparam logic [7:0] ICTL_OFS = 8'h0c; // interrupt_control

	// ***************************************************************
	// field positions
	// ***************************************************************
	localparam int CTRL_EN_BIT = 7;
	localparam int CTRL_OUT_BIT = 5;
	localparam int CTRL_POL_BIT = 4;
	localparam int CTRL_RISE_BIT = 1;
	localparam int CTRL_FALL_BIT = 0;
	localparam int FLAG_BIT = 0;
	localparam int MASK_BIT = 0;
	localparam int ICTL_GIE_BIT = 1;
	localparam int ICTL_PERIPHERAL_IRQ_ENABLE_BIT = 0;

	// ***************************************************************
	// reset values
	// ***************************************************************
	localparam logic CTRL_EN_RST = 1'b0;
	localparam logic CTRL_POL_RST = 1'b0;
	localparam logic CTRL_RISE_RST = 1'b0;
	localparam logic CTRL_FALL_RST = 1'b0;
	localparam logic FLAG_RST = 1'b0;
	localparam logic MASK_RST = 1'b0;
	localparam logic GIE_RST = 1'b0;
	localparam logic PERIPHERAL_IRQ_ENABLE_RST = 1'b0;
	localparam logic CFG_N_RST = 1'b0; // loaded at reset but never seen: until the strap is caught cfg_n_nxt follows the strap input directly

	// ***************************************************************
	// bus codes
	// ***************************************************************
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam int HTRANS_VALID_BIT = 1; // set for NONSEQ and SEQ
	localparam logic HRESP_OKAY = 1'b0;
	localparam logic [7:0] OFS_MASK = 8'hff;

endpackage
`default_nettype wire

// ==== hdl/zc_edge_detect.sv ====
// synchroniser, polarity stage and edge detectors of the zero-cross logic output
`default_nettype none
module zc_edge_detect
	import zero_cross_pkg::*;
(
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic sink_async,
	input wire logic invert,
	output logic out_level,
	output logic rise,
	output logic fall
);

	logic sync1_r, sync1_nxt;
	logic sync2_r, sync2_nxt;
	logic out_r, out_nxt;
	logic out_now;

	// ***************************************************************
	// synchroniser and polarity
	// ***************************************************************
	// the analog sink flag toggles at line rate with no relation to core_clk
	always_comb begin
		sync1_nxt = sink_async;
		sync2_nxt = sync1_r;
	end

	// inversion sits after the synchroniser, so a polarity write alone makes an edge
	assign out_now = sync2_r ^ invert;
	assign out_nxt = out_now;

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			out_r <= 1'b0;
		end else begin
			sync1_r <= sync1_nxt;
			sync2_r <= sync2_nxt;
			out_r <= out_nxt;
		end
	end

	// ***************************************************************
	// edge detectors
	// ***************************************************************
	// both detectors watch the output after inversion
	assign rise = out_now & ~out_r;
	assign fall = ~out_now & out_r;
	assign out_level = out_r;

	// ***************************************************************
	// assertions
	// ***************************************************************
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rstn);

	sequence s_inputs_steady;
		($stable(sink_async) && $stable(invert)) [*3];
	endsequence

	property p_sync_latency;
		s_inputs_steady |=> (out_level == ($past(sink_async) ^ $past(invert)));
	endproperty
	a_sync_latency: assert property (p_sync_latency)
		else $error("logic output does not follow sink flag after synchroniser");

	property p_rise_pulse;
		rise |=> (out_level && !$past(out_level));
	endproperty
	a_rise_pulse: assert property (p_rise_pulse)
		else $error("rise pulse without low-to-high output change");

	property p_pol_edge;
		($changed(invert) && $stable(sync2_r)) |-> (rise || fall);
	endproperty
	a_pol_edge: assert property (p_pol_edge)
		else $error("polarity change produced no edge");

endmodule // zc_edge_detect
`default_nettype wire

// ==== sim/ac_source_model.sv ====
// behavioural ac source behind a series resistor, seen through the sink flag
`default_nettype none
module ac_source_model (
	input wire logic applied_high,
	input wire logic slow,
	input wire logic regulator_en,
	output logic sink_active_in
);
	timeunit 1ns;
	timeprecision 1ps;

	// no pull-up is modelled on the pin; it would fight the regulation
	initial sink_active_in = 1'b0;

	// sink while the source is above the reference, source below it
	// slow mode stands for a comparator that lags by a few cycles
	always @(applied_high, regulator_en, slow) begin
		if (regulator_en) begin
			sink_active_in <= #(slow ? 12 : 1) applied_high;
		end else begin
			// an unregulated pin carries no valid indication, so the flag toggles on every input change
			sink_active_in <= #1 ~sink_active_in;
		end
	end
endmodule // ac_source_model
`default_nettype wire

// ==== sim/tb_top.sv ====
// self-checking bench of the zero-cross detector through its bus and pin
`default_nettype none
module tb_top
	import zero_cross_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic core_clk, rstn, hsel, hwrite, strap_n, pps_d, tris_d, level, slow;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic hreadyout, hresp, sink, reg_en, pad_out, pad_oe, irq;
	int num_errors = 0;
	int comparisons = 0;

	zero_cross_detector dut (
		.core_clk(core_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sink_active_in(sink),
		.always_active_cfg_n(strap_n), .pps_data_in(pps_d), .tris_in(tris_d),
		.regulator_en(reg_en), .pad_out(pad_out), .pad_oe(pad_oe), .irq(irq)
	);

	ac_source_model src (
		.applied_high(level), .slow(slow), .regulator_en(reg_en), .sink_active_in(sink)
	);

	// 200 mhz clock
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	// ***************************************************************
	// bus cycles and comparisons
	// ***************************************************************
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// bounded wait for hready at a rising edge; a hang ends the run
	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 40);
		if (n >= 40) begin
			num_errors++;
			summarize();
		end
	endtask

	// one single word transfer: address phase, then data phase
	task automatic bus(input logic wr, input logic [7:0] ofs, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h0, ofs};
		htrans <= 2'b10;
		hwrite <= wr;
		hsize <= HSIZE_WORD;
		wait_ready();
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= wr ? wd : 32'h0;
		wait_ready();
		rd = hrdata;
		check("hresp", 32'(hresp), 32'(HRESP_OKAY));
	endtask

	task automatic rd_chk(input logic [7:0] ofs, input logic [31:0] exp, input string what);
		bus(1'b0, ofs, 32'h0);
		check(what, rd, exp);
	endtask

	// leaves room for the slow source plus the synchroniser
	task automatic set_level(input logic v);
		level <= v;
		repeat (8) @(posedge core_clk);
	endtask

	task automatic reset_dut(input logic strap);
		rstn <= 1'b0;
		strap_n <= strap;
		repeat (8) @(posedge core_clk);
		rstn <= 1'b1;
		repeat (3) @(posedge core_clk);
	endtask

	// ***************************************************************
	// scenarios
	// ***************************************************************
	task automatic t_pin();
		check("irq", 32'(irq), 32'h0);
		check("regulator_en", 32'(reg_en), 32'h0);
		check("pad_out", 32'(pad_out), 32'h1);
		check("pad_oe", 32'(pad_oe), 32'h1);
		// flip the normal pin controls so the follow path is really exercised
		pps_d <= 1'b0;
		tris_d <= 1'b1;
		repeat (2) @(posedge core_clk);
		check("pad_out", 32'(pad_out), 32'h0);
		check("pad_oe", 32'(pad_oe), 32'h0);
		pps_d <= 1'b1;
		tris_d <= 1'b0;
		bus(1'b1, CTRL_OFS, 32'h80);
		repeat (8) @(posedge core_clk);
		check("regulator_en", 32'(reg_en), 32'h1);
		check("pad_oe", 32'(pad_oe), 32'h0);
		check("pad_out", 32'(pad_out), 32'h0);
		rd_chk(CTRL_OFS, 32'h80, "status source");
		set_level(1'b1);
		rd_chk(CTRL_OFS, 32'ha0, "status sink");
		$display("test pin done");
	endtask

	task automatic t_regs();
		rd_chk(FLAG_OFS, 32'h0, "flag reset");
		rd_chk(MASK_OFS, 32'h0, "mask reset");
		rd_chk(ICTL_OFS, 32'h0, "ictl reset");
		bus(1'b1, 8'h10, 32'hffffffff);
		rd_chk(8'h10, 32'h0, "unmapped");
		bus(1'b1, CTRL_OFS, 32'hffffffff);
		repeat (2) @(posedge core_clk);
		rd_chk(CTRL_OFS, 32'h93, "control layout");
		rd_chk(FLAG_OFS, 32'h1, "flag on polarity");
		// read data stands for the data phase only, then falls back to zero
		@(posedge core_clk);
		check("hrdata idle", hrdata, 32'h0);
		repeat (20) @(posedge core_clk);
		bus(1'b1, FLAG_OFS, 32'h0);
		rd_chk(FLAG_OFS, 32'h1, "flag sticky");
		bus(1'b1, FLAG_OFS, 32'h1);
		rd_chk(FLAG_OFS, 32'h0, "flag cleared");
		set_level(1'b0);
		rd_chk(CTRL_OFS, 32'hb3, "status inverted");
		$display("test regs done");
	endtask

	task automatic t_edges();
		// rise only, fall only, rise only with inverted output
		logic [31:0] cfg [3] = '{32'h82, 32'h81, 32'h92};
		logic up_exp [3] = '{1'b1, 1'b0, 1'b0};
		logic dn_exp [3] = '{1'b0, 1'b1, 1'b1};
		for (int i = 0; i < 3; i++) begin
			slow <= (i == 2);
			bus(1'b1, CTRL_OFS, cfg[i]);
			repeat (2) @(posedge core_clk);
			bus(1'b1, FLAG_OFS, 32'h1);
			set_level(1'b1);
			rd_chk(FLAG_OFS, {31'h0, up_exp[i]}, "flag input up");
			bus(1'b1, FLAG_OFS, 32'h1);
			set_level(1'b0);
			rd_chk(FLAG_OFS, {31'h0, dn_exp[i]}, "flag input down");
			bus(1'b1, FLAG_OFS, 32'h1);
		end
		slow <= 1'b0;
		$display("test edges done");
	endtask

	task automatic t_irq();
		bus(1'b1, CTRL_OFS, 32'h82);
		repeat (2) @(posedge core_clk);
		bus(1'b1, FLAG_OFS, 32'h1);
		set_level(1'b1);
		for (int i = 0; i < 8; i++) begin
			bus(1'b1, MASK_OFS, {31'h0, i[0]});
			bus(1'b1, ICTL_OFS, {30'h0, i[2], i[1]});
			repeat (2) @(posedge core_clk);
			check("irq", 32'(irq), {31'h0, i == 7});
		end
		bus(1'b1, FLAG_OFS, 32'h1);
		repeat (2) @(posedge core_clk);
		check("irq cleared", 32'(irq), 32'h0);
		$display("test irq done");
	endtask

	// the clear lands on the edge where the synchronised rise sets the flag
	task automatic t_set_wins();
		set_level(1'b0);
		bus(1'b1, FLAG_OFS, 32'h1);
		level <= 1'b1;
		@(posedge core_clk);
		bus(1'b1, FLAG_OFS, 32'h1);
		rd_chk(FLAG_OFS, 32'h1, "set over clear");
		check("irq", 32'(irq), 32'h1);
		set_level(1'b0);
		$display("test set_wins done");
	endtask

	task automatic t_strap();
		reset_dut(1'b0);
		check("regulator_en", 32'(reg_en), 32'h1);
		rd_chk(CTRL_OFS, 32'h0, "control reset");
		bus(1'b1, CTRL_OFS, 32'h13);
		repeat (2) @(posedge core_clk);
		rd_chk(FLAG_OFS, 32'h1, "flag with enable clear");
		check("pad_oe", 32'(pad_oe), 32'h0);
		$display("test strap done");
	endtask

	// ***************************************************************
	// main sequence and watchdog
	// ***************************************************************
	initial begin
		rstn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = HSIZE_WORD;
		hwdata = 32'h0;
		strap_n = 1'b1;
		pps_d = 1'b1;
		tris_d = 1'b0;
		level = 1'b0;
		slow = 1'b0;
		reset_dut(1'b1);
		t_pin();
		t_regs();
		t_edges();
		t_irq();
		t_set_wins();
		t_strap();
		summarize();
	end

	initial begin
		repeat (20000) @(posedge core_clk);
		num_errors++;
		$display("watchdog expired");
		summarize();
	end
endmodule // tb_top
`default_nettype wire
